// ==== ephy_defs.svh ====
// Constants for the Ethernet PHY datapath latency, carrier and reset block.
// What this block does
// - 10M transmit nibble reaches pair within two bits
// - 100M MII start code within three bits
// - Symbol mode code reaches pair within seven bits
// - 100M transmit carrier follows enable within four bits
// - 10M transmit carrier on four, off four
// - Received start code reaches MII within 17/9 bits
// - Receive carrier rises 10 to 14 bits
// - Collision rises 9 to 13 bits
// - Receive carrier falls 13 to 18 bits
// - Collision falls 13 to 18 bits after end
// - Power-on reset lasts 40 to 500 ms
// - Hardware reset isolates the device quickly
// - Transmit clock valid within 500 ms of release
// - 10M heartbeat collision pulse after transmit ends
// - 10M bit time is 100 ns
`ifndef EPHY_DEFS_SVH
`define EPHY_DEFS_SVH

`define EPHY_CODE_W 5
`define EPHY_NIB_W 4
`define EPHY_RX_DEPTH 4
`define EPHY_CNT_W 24
`define EPHY_SQE_W 3

`define EPHY_SYM_J 5'h18
`define EPHY_SYM_K 5'h11
`define EPHY_SYM_T 5'h0d
`define EPHY_SYM_R 5'h07
`define EPHY_SYM_IDLE 5'h1f
`define EPHY_SYM_HALT 5'h04
`define EPHY_NIB_PRE 4'h5

`define EPHY_BITS_PER_NIB 4
`define EPHY_CEIL_NIB(b) (((b) + `EPHY_BITS_PER_NIB - 1) / `EPHY_BITS_PER_NIB)
`define EPHY_RX_MII_BITS 17
`define EPHY_RX_STR_BITS 9
`define EPHY_RX_MII_CYC `EPHY_CEIL_NIB(`EPHY_RX_MII_BITS)
`define EPHY_RX_STR_CYC `EPHY_CEIL_NIB(`EPHY_RX_STR_BITS)

`define EPHY_BIT_NS_10 100
`define EPHY_NIB_NS_10 (`EPHY_BITS_PER_NIB * `EPHY_BIT_NS_10)
`define EPHY_SQE_DLY_NS 850
`define EPHY_SQE_LEN_NS 1000
`define EPHY_SQE_DLY_CYC (`EPHY_SQE_DLY_NS / `EPHY_NIB_NS_10)
`define EPHY_SQE_LEN_CYC (`EPHY_SQE_LEN_NS / `EPHY_NIB_NS_10)

`define EPHY_CLK_NS 4
`define EPHY_NS_PER_MS 1000000
`define EPHY_POR_MS 45
`define EPHY_CLKOK_MS 35
`define EPHY_POR_CYC (`EPHY_POR_MS * `EPHY_NS_PER_MS / `EPHY_CLK_NS)
`define EPHY_CLKOK_CYC (`EPHY_CLKOK_MS * `EPHY_NS_PER_MS / `EPHY_CLK_NS)

`endif

// ==== ephy_pkg.sv ====
// Types shared by the Ethernet PHY datapath block.
`default_nettype none
`include "ephy_defs.svh"
package ephy_pkg;

  typedef enum logic [3:0] {
    EPHY_C_POR  = 4'h1,
    EPHY_C_RST  = 4'h2,
    EPHY_C_WAIT = 4'h4,
    EPHY_C_RUN  = 4'h8
  } ephy_core_st_t;

  typedef enum logic [4:0] {
    EPHY_T_IDLE = 5'h01,
    EPHY_T_K    = 5'h02,
    EPHY_T_DATA = 5'h04,
    EPHY_T_TERM = 5'h08,
    EPHY_T_REST = 5'h10
  } ephy_tx_st_t;

  typedef struct packed {
    ephy_core_st_t            state;
    logic [`EPHY_CNT_W-1:0]   cnt;
    logic                     iso;
    logic                     ok;
  } ephy_core_t;

  typedef struct packed {
    ephy_tx_st_t                                 tx_st;
    logic                                        tx_en_q;
    logic [`EPHY_CODE_W-1:0]                     tx_pipe;
    logic [`EPHY_CODE_W-1:0]                     tx_out;
    logic [`EPHY_RX_DEPTH-1:0][`EPHY_CODE_W-1:0] rx_pipe;
    logic                                        rx_act;
    logic                                        rx_act_d;
    logic [`EPHY_NIB_W-1:0]                      rxd;
    logic                                        rx_dv;
    logic                                        rx_er;
    logic                                        crs;
    logic                                        col;
    logic [`EPHY_SQE_W-1:0]                      sqe_cnt;
  } ephy_link_t;

endpackage : ephy_pkg
`default_nettype wire

// ==== ephy_sync.sv ====
// Two-flop synchroniser for levels entering a clock domain.
`default_nettype none
module ephy_sync
  import ephy_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } ephy_sync_t;

  ephy_sync_t st;
  ephy_sync_t next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.meta = d;
    next_st.held = st.meta;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.held;

endmodule : ephy_sync
`default_nettype wire

// ==== ephy_datapath.sv ====
// Ethernet PHY datapath timing, carrier, collision and reset sequencing.
`default_nettype none
`include "ephy_defs.svh"
module ephy_datapath
  import ephy_pkg::*;
#(
  parameter int unsigned POR_CYC   = `EPHY_POR_CYC,
  parameter int unsigned CLKOK_CYC = `EPHY_CLKOK_CYC
) (
  // Core clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // Hardware reset pin
  input  wire logic                    hw_reset_low,
  // Mode straps
  input  wire logic                    mode_100,
  input  wire logic                    mode_stream,
  input  wire logic                    full_duplex,
  // MII transmit, on the link clock
  input  wire logic                    link_clk,
  input  wire logic                    tx_en,
  input  wire logic                    tx_er,
  input  wire logic [`EPHY_NIB_W-1:0]  txd,
  // MII receive, on the link clock
  output logic      [`EPHY_NIB_W-1:0]  rxd,
  output logic                         rx_dv,
  output logic                         rx_er,
  output logic                         crs,
  output logic                         col,
  // Medium code groups, on the link clock
  output logic      [`EPHY_CODE_W-1:0] pair_tx_out,
  input  wire logic [`EPHY_CODE_W-1:0] pair_rx_in,
  // Reset status
  output logic                         isolate,
  output logic                         tx_clk_ok
);

  localparam logic [`EPHY_CNT_W-1:0] POR_LAST   = `EPHY_CNT_W'(POR_CYC - 1);
  localparam logic [`EPHY_CNT_W-1:0] CLKOK_LAST = `EPHY_CNT_W'(CLKOK_CYC - 1);
  localparam int unsigned RX_MII_TAP = `EPHY_RX_MII_CYC - 2;
  localparam int unsigned RX_STR_TAP = `EPHY_RX_STR_CYC - 2;
  localparam logic [`EPHY_SQE_W-1:0] SQE_LOAD =
    `EPHY_SQE_W'(`EPHY_SQE_DLY_CYC + `EPHY_SQE_LEN_CYC - 2);
  localparam logic [`EPHY_SQE_W-1:0] SQE_LEN = `EPHY_SQE_W'(`EPHY_SQE_LEN_CYC);

  // 4B/5B data code for one nibble.
  function automatic logic [`EPHY_CODE_W-1:0] ephy_enc(input logic [`EPHY_NIB_W-1:0] n);
    logic [`EPHY_CODE_W-1:0] c;
    case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      default: c = 5'h1d;
    endcase
    return c;
  endfunction : ephy_enc

  // Inverse of the data code; the top bit says whether the code was a data code.
  function automatic logic [`EPHY_CODE_W-1:0] ephy_dec(input logic [`EPHY_CODE_W-1:0] c);
    logic [`EPHY_CODE_W-1:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (ephy_enc(`EPHY_NIB_W'(i)) == c) begin
        r = {1'b1, `EPHY_NIB_W'(i)};
      end
    end
    return r;
  endfunction : ephy_dec

  // Core domain: power-on and hardware reset sequencing.

  ephy_core_t core;
  ephy_core_t next_core;
  logic       hw_ok;

  ephy_sync #(.W(1)) u_hw_sync (
    .clk (clock),
    .d   (hw_reset_low),
    .q   (hw_ok)
  );

  always_comb begin
    next_core = core;
    next_core.cnt = core.cnt + `EPHY_CNT_W'(1);
    case (core.state)
      EPHY_C_POR: begin
        if (core.cnt == POR_LAST) begin
          next_core.state = EPHY_C_RUN;
        end
      end
      EPHY_C_RST: begin
        next_core.cnt = '0;
        if (hw_ok) begin
          next_core.state = EPHY_C_WAIT;
        end
      end
      EPHY_C_WAIT: begin
        if (core.cnt == CLKOK_LAST) begin
          next_core.state = EPHY_C_RUN;
        end
      end
      EPHY_C_RUN: begin
        next_core.cnt = '0;
      end
      default: begin
        next_core.state = EPHY_C_POR;
        next_core.cnt   = '0;
      end
    endcase
    // A pulse shorter than the controller's minimum may still isolate the part;
    // one that spans a core clock edge is never ignored, so a marginal reset errs on the safe side.
    if (!hw_ok) begin
      next_core.state = EPHY_C_RST;
      next_core.cnt   = '0;
    end
    next_core.iso = (next_core.state != EPHY_C_RUN);
    next_core.ok  = (next_core.state == EPHY_C_RUN);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      core.state <= EPHY_C_POR;
      core.cnt   <= '0;
      core.iso   <= 1'b1;
      core.ok    <= 1'b0;
    end else begin
      core <= next_core;
    end
  end

  assign isolate   = core.iso;
  assign tx_clk_ok = core.ok;

  // Link domain: transmit coding, receive carrier and collision.

  ephy_link_t              link;
  ephy_link_t              next_link;
  logic                    link_ok;
  logic                    link_rst;
  logic [2:0]              modes;
  logic                    m10;
  logic                    mstr;
  logic                    mmii;
  logic                    half;
  logic                    rx_car;
  logic                    sqe_hb;
  logic [`EPHY_CODE_W-1:0] rx_head;
  logic [`EPHY_CODE_W-1:0] rx_tap;
  logic [`EPHY_CODE_W-1:0] rx_dec;

  // The link side stays in reset until the core reports a valid transmit clock.
  ephy_sync #(.W(1)) u_ok_sync (
    .clk (link_clk),
    .d   (core.ok),
    .q   (link_ok)
  );

  ephy_sync #(.W(3)) u_mode_sync (
    .clk (link_clk),
    .d   ({mode_100, mode_stream, full_duplex}),
    .q   (modes)
  );

  assign link_rst = ~link_ok;
  assign m10      = ~modes[2];
  assign mstr     = modes[2] & modes[1];
  assign mmii     = modes[2] & ~modes[1];
  assign half     = ~modes[0];
  assign rx_head  = link.rx_pipe[0];
  assign rx_car   = link.rx_act | link.rx_act_d;
  assign sqe_hb   = (link.sqe_cnt != '0) && (link.sqe_cnt <= SQE_LEN);
  assign rx_tap   = m10  ? link.rx_pipe[0] :
                    mstr ? link.rx_pipe[RX_STR_TAP] : link.rx_pipe[RX_MII_TAP];
  assign rx_dec   = ephy_dec(rx_tap);

  always_comb begin
    next_link = link;
    next_link.tx_en_q = tx_en;
    next_link.tx_pipe = {tx_er, txd};

    // Transmit path: one nibble clock equals four bit times.
    next_link.tx_st = EPHY_T_IDLE;
    if (m10) begin
      next_link.tx_out = {tx_en, txd};
    end else if (mstr) begin
      next_link.tx_out = link.tx_pipe;
    end else begin
      case (link.tx_st)
        EPHY_T_IDLE: begin
          if (tx_en) begin
            next_link.tx_out = `EPHY_SYM_J;
            next_link.tx_st  = EPHY_T_K;
          end else begin
            next_link.tx_out = `EPHY_SYM_IDLE;
          end
        end
        EPHY_T_K: begin
          next_link.tx_out = `EPHY_SYM_K;
          next_link.tx_st  = tx_en ? EPHY_T_DATA : EPHY_T_TERM;
        end
        EPHY_T_DATA: begin
          if (tx_en) begin
            next_link.tx_out = tx_er ? `EPHY_SYM_HALT : ephy_enc(txd);
            next_link.tx_st  = EPHY_T_DATA;
          end else begin
            next_link.tx_out = `EPHY_SYM_T;
            next_link.tx_st  = EPHY_T_REST;
          end
        end
        EPHY_T_TERM: begin
          next_link.tx_out = `EPHY_SYM_T;
          next_link.tx_st  = EPHY_T_REST;
        end
        EPHY_T_REST: begin
          // A frame that starts here waits one nibble; the end code must finish.
          next_link.tx_out = `EPHY_SYM_R;
        end
        default: begin
          next_link.tx_out = `EPHY_SYM_IDLE;
        end
      endcase
    end

    // Receive carrier: in 100M a start code sets, end code or idle clears; in 10M it follows bit 4 of the code.
    next_link.rx_pipe = {link.rx_pipe[`EPHY_RX_DEPTH-2:0], pair_rx_in};
    if (m10) begin
      next_link.rx_act = rx_head[4];
    end else begin
      next_link.rx_act = (rx_head == `EPHY_SYM_J) ||
                         (link.rx_act && rx_head != `EPHY_SYM_T &&
                          rx_head != `EPHY_SYM_IDLE);
    end
    next_link.rx_act_d = link.rx_act;

    // Carrier and collision; the raw transmit enable keeps the transmit
    // carrier at a single nibble of latency in both directions.
    next_link.crs = rx_car | (half & tx_en);
    next_link.col = (half & tx_en & rx_car) | (m10 & half & sqe_hb);

    // Heartbeat after a 10M transmission; the two output stages are counted in.
    if (link.sqe_cnt != '0) begin
      next_link.sqe_cnt = link.sqe_cnt - `EPHY_SQE_W'(1);
    end
    if (m10 && half && link.tx_en_q && !tx_en) begin
      next_link.sqe_cnt = SQE_LOAD;
    end

    // Receive data towards the MAC.
    if (m10) begin
      next_link.rxd   = rx_tap[3:0];
      next_link.rx_dv = rx_tap[4];
      next_link.rx_er = 1'b0;
    end else if (mstr) begin
      next_link.rxd   = rx_tap[3:0];
      next_link.rx_er = rx_tap[4];
      next_link.rx_dv = 1'b0;
    end else if (rx_tap == `EPHY_SYM_J || rx_tap == `EPHY_SYM_K) begin
      next_link.rxd   = `EPHY_NIB_PRE;
      next_link.rx_dv = 1'b1;
      next_link.rx_er = 1'b0;
    end else if (rx_tap == `EPHY_SYM_T || rx_tap == `EPHY_SYM_IDLE ||
                 rx_tap == `EPHY_SYM_R) begin
      next_link.rxd   = '0;
      next_link.rx_dv = 1'b0;
      next_link.rx_er = 1'b0;
    end else begin
      next_link.rxd   = rx_dec[3:0];
      next_link.rx_er = link.rx_dv & ~rx_dec[4];
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link         <= '0;
      link.tx_st   <= EPHY_T_IDLE;
      link.tx_out  <= `EPHY_SYM_IDLE;
      link.rx_pipe <= '0;
    end else begin
      link <= next_link;
    end
  end

  assign pair_tx_out = link.tx_out;
  assign rxd         = link.rxd;
  assign rx_dv       = link.rx_dv;
  assign rx_er       = link.rx_er;
  assign crs         = link.crs;
  assign col         = link.col;

  // Checks on the link and core timing.

  tx10_lat_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (m10 && tx_en) |=> pair_tx_out == {1'b1, $past(txd)})
    else $error("10M nibble late on pair");

  tx100_start_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (mmii && tx_en && link.tx_st == EPHY_T_IDLE) |=> pair_tx_out == `EPHY_SYM_J)
    else $error("100M start code late");

  stream_lat_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (mstr ##1 mstr) |=> pair_tx_out == $past({tx_er, txd}, 2))
    else $error("symbol mode code late");

  crs_tx_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (half && tx_en) |=> crs)
    else $error("transmit carrier late");

  crs_txoff_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (half && $fell(tx_en) && !rx_car) |=> !crs)
    else $error("transmit carrier held too long");

  rx_lat_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (mmii && pair_rx_in == `EPHY_SYM_J) ##1 mmii[*4] |=> (rx_dv && rxd == `EPHY_NIB_PRE))
    else $error("received start code late");

  crs_rx_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (!m10 && pair_rx_in == `EPHY_SYM_J && !tx_en && !rx_car) |=> !crs ##1 !crs ##1 crs)
    else $error("receive carrier outside window");

  col_on_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (!m10 && half && tx_en && pair_rx_in == `EPHY_SYM_J) ##1 tx_en[*2] |=> col)
    else $error("collision late");

  crs_off_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (!m10 && !half && rx_car && next_link.rx_act && pair_rx_in == `EPHY_SYM_T)
    ##1 (pair_rx_in != `EPHY_SYM_J) |-> crs ##1 crs ##1 crs ##1 !crs)
    else $error("receive carrier off outside window");

  col_off_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (!m10 && pair_rx_in == `EPHY_SYM_T) ##1 (pair_rx_in != `EPHY_SYM_J) |-> ##3 !col)
    else $error("collision held too long");

  sqe_pulse_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (m10 && half && $fell(tx_en) && link.sqe_cnt == '0) |=> !col ##1 col ##1 col)
    else $error("heartbeat pulse wrong");

  sqe_shape_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (m10 && half && $fell(tx_en)) ##1 (!tx_en && m10)[*3] |-> ($past(col) && col) ##1 !col)
    else $error("heartbeat pulse timing wrong");

  iso_fast_a: assert property (@(posedge clock) disable iff (rst)
    $fell(hw_reset_low) |-> ##[1:15] isolate)
    else $error("isolation late after hardware reset");

  clk_ok_a: assert property (@(posedge clock) disable iff (rst)
    $rose(tx_clk_ok) |-> $past(core.cnt) == POR_LAST || $past(core.cnt) == CLKOK_LAST)
    else $error("clock valid without full wait");

  ok_iso_a: assert property (@(posedge clock) disable iff (rst)
    !hw_ok |=> isolate && !tx_clk_ok)
    else $error("clock valid during hardware reset");

  frame_c: cover property (@(posedge link_clk) disable iff (link_rst)
    mmii && pair_tx_out == `EPHY_SYM_J ##[1:40] pair_tx_out == `EPHY_SYM_T);
  collide_c: cover property (@(posedge link_clk) disable iff (link_rst) $rose(col) && !m10);
  sqe_c: cover property (@(posedge link_clk) disable iff (link_rst) m10 && $rose(col));
  hwrst_c: cover property (@(posedge clock) disable iff (rst) $fell(isolate) && hw_ok);

endmodule : ephy_datapath
`default_nettype wire

// ==== ephy_mac_model.sv ====
// Behavioural MII controller that sends transmit frames and pulses the hardware reset pin.
`default_nettype none
`include "ephy_defs.svh"
module ephy_mac_model
  import ephy_pkg::*;
(
  // Clocks and link status
  input  wire logic                   clock,
  input  wire logic                   link_clk,
  input  wire logic                   tx_clk_ok,
  // Hardware reset pin
  output logic                        hw_reset_low,
  // MII transmit
  output logic                        tx_en,
  output logic                        tx_er,
  output logic [`EPHY_NIB_W-1:0]      txd
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    hw_reset_low = 1'b1;
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = 4'h0;
  end

  // One nibble per link cycle; entered on a link edge, returns on the edge that drops tx_en.
  task automatic frame(input logic [3:0] nib, input logic er, input int len);
    int i;
    if (tx_clk_ok !== 1'b1) begin
      wait (tx_clk_ok === 1'b1);
      repeat (4) @(posedge link_clk);
    end
    for (i = 0; i < len; i++) begin
      tx_en <= 1'b1;
      tx_er <= er;
      txd <= nib + 4'(i);
      @(posedge link_clk);
    end
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    // Released data lines show the inverse so a stale nibble is never mistaken for data.
    txd <= ~(nib + 4'(len - 1));
  endtask : frame

  // 125 core cycles of 4 ns give the 500 ns minimum pulse.
  task automatic hw_pulse();
    hw_reset_low <= 1'b0;
    repeat (125) @(posedge clock);
    hw_reset_low <= 1'b1;
  endtask : hw_pulse
endmodule : ephy_mac_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the Ethernet PHY datapath timing block.
`default_nettype none
`include "ephy_defs.svh"
module tb_top
  import ephy_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int POR   = 20;
  localparam int CLKOK = 30;

  logic       clock, rst, link_clk, hw_reset_low;
  logic       mode_100, mode_stream, full_duplex;
  logic       tx_en, tx_er, rx_dv, rx_er, crs, col, isolate, tx_clk_ok;
  logic [3:0] txd, rxd;
  logic [4:0] pair_tx_out, pair_rx_in;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         n;

  typedef struct {
    logic       m100;
    logic       mstr;
    logic       er;
    logic [3:0] nib;
    logic [4:0] code;
    int         lat;
  } ephy_row_t;

  ephy_row_t rows [7] = '{
    '{1'b0, 1'b0, 1'b0, 4'h0, 5'h10, 1}, '{1'b0, 1'b0, 1'b0, 4'ha, 5'h1a, 1},
    '{1'b0, 1'b0, 1'b0, 4'h6, 5'h16, 1}, '{1'b1, 1'b0, 1'b0, 4'h5, 5'h18, 1},
    '{1'b1, 1'b1, 1'b1, 4'h8, 5'h18, 2}, '{1'b1, 1'b1, 1'b0, 4'hd, 5'h0d, 2},
    '{1'b1, 1'b1, 1'b1, 4'h1, 5'h11, 2}};

  always #2 clock = ~clock;

  // The link clock starts at an odd offset so its phase bears no relation to the core clock.
  initial begin
    link_clk = 1'b0;
    #17.3;
    forever #62.5 link_clk = ~link_clk;
  end

  ephy_datapath #(.POR_CYC(POR), .CLKOK_CYC(CLKOK)) dut (
    .clock(clock), .rst(rst), .hw_reset_low(hw_reset_low), .mode_100(mode_100),
    .mode_stream(mode_stream), .full_duplex(full_duplex), .link_clk(link_clk),
    .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .crs(crs), .col(col), .pair_tx_out(pair_tx_out), .pair_rx_in(pair_rx_in),
    .isolate(isolate), .tx_clk_ok(tx_clk_ok));

  ephy_mac_model mac (
    .clock(clock), .link_clk(link_clk), .tx_clk_ok(tx_clk_ok),
    .hw_reset_low(hw_reset_low), .tx_en(tx_en), .tx_er(tx_er), .txd(txd));

  task automatic lk(input int k);
    repeat (k) @(posedge link_clk);
  endtask : lk

  task automatic cmp_code(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_code

  task automatic cmp_nib(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_nib

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic set_mode(input logic m, input logic s);
    mode_100 <= m;
    mode_stream <= s;
    pair_rx_in <= m ? 5'h1f : 5'h00;
    lk(8);
  endtask : set_mode

  // Frame on the medium: start, preamble, three zero nibbles, end, reset, idle.
  task automatic rx_seq();
    logic [4:0] seq [8] = '{5'h18, 5'h11, 5'h1e, 5'h1e, 5'h1e, 5'h0d, 5'h07, 5'h1f};
    for (int i = 0; i < 8; i++) begin
      pair_rx_in <= seq[i];
      @(posedge link_clk);
    end
  endtask : rx_seq

  task automatic cnt_ok(output int c);
    c = 0;
    while (tx_clk_ok !== 1'b1 && c < 2000) begin
      @(posedge clock);
      #1;
      c++;
    end
  endtask : cnt_ok

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    #200us;
    error_cnt++;
    end_sim();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    mode_100 = 1'b1;
    mode_stream = 1'b0;
    full_duplex = 1'b0;
    pair_rx_in = 5'h1f;
    repeat (20) @(posedge clock);
    #1 cmp_bit(isolate, 1'b1);
    cmp_bit(tx_clk_ok, 1'b0);
    @(posedge clock);
    rst <= 1'b0;
    cnt_ok(n);
    cmp_bit(logic'(n >= POR - 2 && n <= POR + 4), 1'b1);
    repeat (4) @(posedge clock);
    #1 cmp_bit(isolate, 1'b0);
    done("reset");
    lk(6);
    foreach (rows[i]) begin
      set_mode(rows[i].m100, rows[i].mstr);
      fork mac.frame(rows[i].nib, rows[i].er, 1); join_none
      lk(rows[i].lat);
      #1 cmp_code(pair_tx_out, rows[i].code);
      if (!rows[i].mstr) cmp_bit(crs, 1'b1);
      lk(6);
    end
    done("rows");
    for (int m = 1; m >= 0; m--) begin
      set_mode(m[0], 1'b0);
      fork mac.frame(4'h3, 1'b0, 3); join_none
      lk(3);
      #1 cmp_bit(crs, 1'b1);
      lk(1);
      #1 cmp_bit(crs, 1'b0);
      lk(1);
      #1 cmp_bit(col, ~m[0]);
      lk(1);
      #1 cmp_bit(col, ~m[0]);
      lk(1);
      #1 cmp_bit(col, 1'b0);
      lk(4);
    end
    done("transmit end and heartbeat");
    set_mode(1'b1, 1'b0);
    fork rx_seq(); join_none
    lk(2);
    #1 cmp_bit(crs, 1'b0);
    lk(1);
    #1 cmp_bit(crs, 1'b1);
    lk(2);
    #1 cmp_bit(rx_dv, 1'b1);
    cmp_nib(rxd, 4'h5);
    lk(3);
    #1 cmp_bit(crs, 1'b1);
    lk(1);
    #1 cmp_bit(crs, 1'b0);
    lk(4);
    set_mode(1'b1, 1'b1);
    fork rx_seq(); join_none
    lk(3);
    #1 cmp_nib(rxd, 4'h8);
    cmp_bit(rx_er, 1'b1);
    lk(8);
    done("receive");
    set_mode(1'b1, 1'b0);
    for (int fd = 0; fd < 2; fd++) begin
      full_duplex <= fd[0];
      lk(4);
      fork mac.frame(4'h5, 1'b0, 20); join_none
      lk(4);
      fork rx_seq(); join_none
      lk(2);
      #1 cmp_bit(col, 1'b0);
      lk(1);
      #1 cmp_bit(col, ~fd[0]);
      lk(5);
      #1 cmp_bit(col, ~fd[0]);
      lk(1);
      #1 cmp_bit(col, 1'b0);
      lk(16);
    end
    done("collision");
    @(posedge clock);
    fork mac.hw_pulse(); join_none
    n = 0;
    while (isolate !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    cmp_bit(logic'(n <= 15), 1'b1);
    cmp_bit(tx_clk_ok, 1'b0);
    for (int k = 0; k < 200 && hw_reset_low !== 1'b1; k++) @(posedge clock);
    cnt_ok(n);
    cmp_bit(logic'(n >= CLKOK - 2 && n <= CLKOK + 6), 1'b1);
    done("hardware reset");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
